// File: verilog/lcd_bias_pkg.sv
package lcd_bias_pkg;
  // ==========================================================================
  // Register map
  localparam logic [3:0] ADDR_LCD_CONTROL_0 = 4'h0;
  localparam logic [3:0] ADDR_LCD_CONTROL_1 = 4'h4;
  localparam logic [3:0] ADDR_BIAS_STATUS = 4'h8;
  localparam logic [7:0] LCD_CONTROL_0_RESET = 8'h00;
  localparam logic [7:0] LCD_CONTROL_1_RESET = 8'h00;
  // Implemented bits of control 1; bit 4 reads as zero
  localparam logic [7:0] LCD_CONTROL_1_MASK = 8'hEF;
  // ==========================================================================
  // Field positions, control 0
  localparam int WAVE_TYPE_BIT = 7;
  localparam int BIAS_TYPE_BIT = 6;
  localparam int CSRC_LSB = 4;
  localparam int RES_CODE_LSB = 1;
  localparam int DRIVE_EN_BIT = 0;
  // Field positions, control 1
  localparam int QC_TIME_LSB = 5;
  localparam int RATIO_LSB = 0;
  // ==========================================================================
  // Codes
  localparam logic [1:0] CSRC_EXT_PIN = 2'h0;
  localparam logic [1:0] CSRC_REF_TO_LOW = 2'h1;
  localparam logic [1:0] CSRC_VDD_TO_MID = 2'h2;
  localparam logic [1:0] CSRC_VDD_TO_TOP = 2'h3;
  localparam logic [2:0] RES_CODE_1170K = 3'h0;
  localparam logic [2:0] RES_CODE_225K = 3'h1;
  localparam logic [2:0] RES_CODE_60K = 3'h2;
  localparam logic [2:0] RES_CODE_QC_1170K = 3'h3;
  // One-hot resistor selections driven to the analog network
  localparam logic [2:0] RES_1170K = 3'h1;
  localparam logic [2:0] RES_225K = 3'h2;
  localparam logic [2:0] RES_60K = 3'h4;
  localparam logic [4:0] RATIO_BASE = 5'h08;
  localparam logic [4:0] RATIO_FULL = 5'h10;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lcd_bias_pkg

// File: verilog/quick_charge_timer.sv
`timescale 1ns/1ps
`default_nettype none
module quick_charge_timer
  import lcd_bias_pkg::*;
#(
  parameter int QC_TIME_WIDTH = 3
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic lcd_reset,
  input wire logic phase_start,
  input wire logic sub_clk_tick,
  input wire logic [QC_TIME_WIDTH-1:0] quick_charge_time,
  output logic low_res_window
);
  logic [QC_TIME_WIDTH:0] count;

  // ==========================================================================
  // Low-resistance interval
  // Count sub-clock periods
  always_ff @(posedge core_clk)
  begin
    if (!resetn || lcd_reset)
    begin
      count <= '0;
      low_res_window <= 1'b0;
    end
    else if (phase_start)
    begin
      count <= '0;
      low_res_window <= 1'b1;
    end
    else if (low_res_window && sub_clk_tick)
    begin
      // Window covers code+1 periods
      if (count == {1'b0, quick_charge_time})
        low_res_window <= 1'b0;
      count <= count + 1'b1;
    end
  end
endmodule : quick_charge_timer
`default_nettype wire

// File: verilog/lcd_bias_ctrl.sv
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lcd_bias_ctrl
  import lcd_bias_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sleep_mode,
  input wire logic sub_clk_tick,
  input wire logic phase_start,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic lcd_reset,
  output logic wave_type_b,
  output logic charge_pump_en,
  output logic [1:0] cbias_source_sel,
  output logic [2:0] res_select,
  output logic [4:0] top_level_ratio,
  output logic rbias_one_third_en
);
  logic [7:0] lcd_control_0;
  logic [7:0] lcd_control_1;
  logic [3:0] aw_addr;
  logic aw_held;
  logic [7:0] w_data;
  logic w_strb0;
  logic w_held;
  logic low_res_window;
  logic [2:0] next_res_select;
  logic [4:0] next_top_level_ratio;
  logic [2:0] rbias_resistor_sel;
  logic [3:0] ratio;
  logic bias_cap;
  logic next_lcd_reset;

  assign rbias_resistor_sel = lcd_control_0[RES_CODE_LSB +: 3];
  assign ratio = lcd_control_1[RATIO_LSB +: 4];
  assign bias_cap = lcd_control_0[BIAS_TYPE_BIT];
  assign next_lcd_reset = !lcd_control_0[DRIVE_EN_BIT] || sleep_mode;

  // ==========================================================================
  // AXI4-Lite write path
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata[7:0];
        w_strb0 <= s_axi_wstrb[0];
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        // Status word is read-only
        s_axi_bresp <= (aw_addr == ADDR_LCD_CONTROL_0 || aw_addr == ADDR_LCD_CONTROL_1)
                       ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Control registers
  // Bias type resets resistive
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      lcd_control_0 <= LCD_CONTROL_0_RESET;
      lcd_control_1 <= LCD_CONTROL_1_RESET;
    end
    else if (aw_held && w_held && !s_axi_bvalid && w_strb0)
    begin
      if (aw_addr == ADDR_LCD_CONTROL_0)
        lcd_control_0 <= w_data;
      if (aw_addr == ADDR_LCD_CONTROL_1)
        lcd_control_1 <= w_data & LCD_CONTROL_1_MASK;
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_LCD_CONTROL_0: s_axi_rdata <= {24'h000000, lcd_control_0};
        ADDR_LCD_CONTROL_1: s_axi_rdata <= {24'h000000, lcd_control_1};
        // Live view of what the analog network is being told
        ADDR_BIAS_STATUS: s_axi_rdata <= {26'h0, low_res_window, charge_pump_en,
                                          lcd_reset, res_select};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================================
  // Quick-charge interval
  // Time field drives timer
  quick_charge_timer #(
    .QC_TIME_WIDTH(3)
  ) u_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .lcd_reset(next_lcd_reset),
    .phase_start(phase_start),
    .sub_clk_tick(sub_clk_tick),
    .quick_charge_time(lcd_control_1[QC_TIME_LSB +: 3]),
    .low_res_window(low_res_window)
  );

  // ==========================================================================
  // Resistor and ratio decode
  always_comb
  begin
    if (rbias_resistor_sel[2])
      next_res_select = low_res_window ? RES_60K : RES_225K;
    else
    begin
      unique case (rbias_resistor_sel[1:0])
        RES_CODE_1170K[1:0]: next_res_select = RES_1170K;
        RES_CODE_225K[1:0]: next_res_select = RES_225K;
        RES_CODE_60K[1:0]: next_res_select = RES_60K;
        RES_CODE_QC_1170K[1:0]: next_res_select = low_res_window ? RES_60K : RES_1170K;
      endcase
    end
    if (ratio[3])
      next_top_level_ratio = RATIO_FULL;
    else
      next_top_level_ratio = RATIO_BASE + {2'b00, ratio[2:0]};
  end

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      lcd_reset <= 1'b1;
      wave_type_b <= 1'b0;
      charge_pump_en <= 1'b0;
      cbias_source_sel <= CSRC_EXT_PIN;
      res_select <= RES_1170K;
      top_level_ratio <= RATIO_BASE;
      rbias_one_third_en <= 1'b0;
    end
    else
    begin
      lcd_reset <= next_lcd_reset;
      wave_type_b <= lcd_control_0[WAVE_TYPE_BIT];
      charge_pump_en <= bias_cap && !next_lcd_reset;
      cbias_source_sel <= lcd_control_0[CSRC_LSB +: 2];
      res_select <= next_res_select;
      top_level_ratio <= next_top_level_ratio;
      rbias_one_third_en <= !bias_cap && !next_lcd_reset;
    end
  end
endmodule : lcd_bias_ctrl
`default_nettype wire

// File: tb/lcd_bias_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Port checker
module lcd_bias_chk
  import lcd_bias_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sleep_mode,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic lcd_reset,
  input wire logic charge_pump_en,
  input wire logic rbias_one_third_en,
  input wire logic [2:0] res_select,
  input wire logic [4:0] top_level_ratio
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  chk_sleep_reset: assert property (sleep_mode |=> lcd_reset)
    else $error("sleep left lcd running");
  chk_bias_gated: assert property (lcd_reset |-> !charge_pump_en && !rbias_one_third_en)
    else $error("bias active in reset");
  chk_one_bias: assert property (!lcd_reset |-> charge_pump_en ^ rbias_one_third_en)
    else $error("bias type not exclusive");
  chk_res_onehot: assert property ($onehot(res_select))
    else $error("resistor select not one-hot");
  chk_ratio_range: assert property (top_level_ratio inside {[5'h08:5'h10]})
    else $error("ratio out of range");
  chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_rdata_stable: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while waiting");
endmodule : lcd_bias_chk
bind lcd_bias_ctrl lcd_bias_chk u_chk (
  .core_clk(core_clk),
  .resetn(resetn),
  .sleep_mode(sleep_mode),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata),
  .lcd_reset(lcd_reset),
  .charge_pump_en(charge_pump_en),
  .rbias_one_third_en(rbias_one_third_en),
  .res_select(res_select),
  .top_level_ratio(top_level_ratio)
);
`default_nettype wire

// File: tb/lcd_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Panel timing: tick every 4 cycles, phase every 10 ticks
module lcd_panel_model (
  input wire logic core_clk,
  input wire logic resetn,
  output logic sub_clk_tick,
  output logic phase_start
);
  int div;
  int ticks;
  // Phase opens one cycle after a tick, so window edges stay unambiguous
  always_ff @(posedge core_clk)
  begin
    div <= (!resetn || div == 3) ? 0 : div + 1;
    ticks <= !resetn ? 0 : (ticks + (sub_clk_tick ? 1 : 0)) % 10;
    sub_clk_tick <= resetn && div == 3;
    phase_start <= resetn && sub_clk_tick && ticks == 9;
  end
endmodule : lcd_panel_model
`default_nettype wire

// File: tb/lcd_bias_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Bench
module lcd_bias_ctrl_tb_top
  import lcd_bias_pkg::*;
;
  logic core_clk = 1'h0, resetn = 1'h0, sleep_mode = 1'h0, sub_clk_tick, phase_start;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, lcd_reset, wave_type_b, charge_pump_en, rbias_one_third_en;
  logic [1:0] s_axi_bresp, s_axi_rresp, cbias_source_sel;
  logic [2:0] res_select;
  logic [4:0] top_level_ratio;
  int err_count = 0, n_checks = 0;
  always #2.5 core_clk = ~core_clk;
  lcd_bias_ctrl u_dut (
    .core_clk(core_clk),
    .resetn(resetn),
    .sleep_mode(sleep_mode),
    .sub_clk_tick(sub_clk_tick),
    .phase_start(phase_start),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .lcd_reset(lcd_reset),
    .wave_type_b(wave_type_b),
    .charge_pump_en(charge_pump_en),
    .cbias_source_sel(cbias_source_sel),
    .res_select(res_select),
    .top_level_ratio(top_level_ratio),
    .rbias_one_third_en(rbias_one_third_en)
  );
  lcd_panel_model u_far (
    .core_clk(core_clk),
    .resetn(resetn),
    .sub_clk_tick(sub_clk_tick),
    .phase_start(phase_start)
  );
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : ck
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    logic aw = 1'h0, w = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w))
    begin
      @(posedge core_clk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    ck(s_axi_bresp, r);
    repeat (2) @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge core_clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    ck(s_axi_rdata, {24'h0, e});
    ck(s_axi_rresp, r);
    @(posedge core_clk);
  endtask : rd
  task automatic t_bias();
    rd(ADDR_LCD_CONTROL_0, LCD_CONTROL_0_RESET, RESP_OKAY);
    rd(ADDR_LCD_CONTROL_1, LCD_CONTROL_1_RESET, RESP_OKAY);
    rd(4'hC, 8'h00, RESP_SLVERR);
    rd(ADDR_BIAS_STATUS, {2'h0, 1'h0, 1'h0, 1'h1, RES_1170K}, RESP_OKAY);
    ck({lcd_reset, res_select, top_level_ratio}, {1'h1, RES_1170K, 5'h08});
    wr(ADDR_LCD_CONTROL_0, 8'h41, RESP_OKAY);
    ck({lcd_reset, charge_pump_en, rbias_one_third_en}, 3'h2);
    sleep_mode <= 1'h1;
    repeat (2) @(posedge core_clk);
    ck({lcd_reset, charge_pump_en}, 2'h2);
    sleep_mode <= 1'h0;
    wr(ADDR_LCD_CONTROL_0, 8'h01, RESP_OKAY);
    ck({charge_pump_en, rbias_one_third_en}, 2'h1);
    wr(ADDR_BIAS_STATUS, 8'hFF, RESP_SLVERR);
    wr(ADDR_LCD_CONTROL_0, 8'h00, RESP_OKAY);
    ck(lcd_reset, 1'h1);
    $display("bias test done");
  endtask : t_bias
  task automatic t_codes();
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_LCD_CONTROL_0, 8'h81 | 8'(c << 4), RESP_OKAY);
      ck({wave_type_b, cbias_source_sel}, {1'h1, 2'(c)});
    end
    // Bench supply is taken as high enough for every ratio
    for (int n = 0; n < 16; n++)
    begin
      wr(ADDR_LCD_CONTROL_1, 8'(n), RESP_OKAY);
      ck(top_level_ratio, n > 7 ? 5'h10 : 5'(8 + n));
    end
    wr(ADDR_LCD_CONTROL_1, 8'hFF, RESP_OKAY);
    rd(ADDR_LCD_CONTROL_1, 8'hEF, RESP_OKAY);
    $display("code test done");
  endtask : t_codes
  task automatic t_charge();
    logic [2:0] rs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic [2:0] qt [6] = '{3'h7, 3'h7, 3'h0, 3'h7, 3'h0, 3'h3};
    logic [2:0] hi [6] = '{RES_1170K, RES_225K, RES_60K, RES_1170K, RES_225K, RES_225K};
    int lo, up, len;
    logic [2:0] first;
    // Fixed codes expect no low window at all, so they share the loop
    for (int m = 0; m < 6; m++)
    begin
      wr(ADDR_LCD_CONTROL_1, {qt[m], 5'h08}, RESP_OKAY);
      wr(ADDR_LCD_CONTROL_0, {4'h0, rs[m], 1'h1}, RESP_OKAY);
      repeat (2) do @(posedge core_clk); while (phase_start !== 1'h1);
      lo = 0;
      up = 0;
      len = (m < 3) ? 0 : 4 * (qt[m] + 1);
      for (int c = 1; c <= 38; c++)
      begin
        @(posedge core_clk);
        if (c == 3) first = res_select;
        lo += (res_select === RES_60K && m != 2) ? 1 : 0;
        up += (res_select === hi[m]) ? 1 : 0;
      end
      ck(lo >= len - 1 && lo <= len + (m < 3 ? 0 : 1), 1'h1);
      ck(lo + up, 38);
      if (m > 2) ck(first, RES_60K);
    end
    $display("charge test done");
  endtask : t_charge
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    t_bias();
    t_codes();
    t_charge();
    print_verdict();
  end
  // Run needs about 1000 cycles; 20000 leaves wide margin
  initial
  begin
    #100000;
    $display("unexpected at %0t: watchdog expired", $time);
    err_count++;
    print_verdict();
  end
endmodule : lcd_bias_ctrl_tb_top
`default_nettype wire
